// file: core/uefc_core.sv
`timescale 1ns/1ps
// Contract
// - Unlock bit gates writes to enhanced bits.
// - Reset clears enhanced bits and unlock bit.
// - Second Xoff match stored, status bit four set.
// - Compare bit zero against received LSB.
// - First pair select keeps normal behaviour.
// - Second pair select drops match, raises both.
// - Auto RTS interrupts at trigger level.
// - Auto RTS high above, low below level.
// - Without auto RTS, pin follows software.
// - Auto CTS halts transmit while CTS high.
// - Four write-only flow characters reset zero.
// - Divisor loads one only at power-up.
// - Reset clears deltas; status shows inverted inputs.
// - Select bits changed only through zero.
// - Auto CTS at bit seven; CTS status inverted.
module uefc_core #(
    parameter int DEPTH = 16
) (
    // Clock, pin reset and power-on reset.
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    input  wire logic                   por_n,
    // Host register port.
    input  wire uefc_pkg::uefc_bus_req_s bus,
    output logic [7:0]                  rdata,
    // Received characters from the deserialiser.
    input  wire logic                   rx_valid,
    output logic                        rx_ready,
    input  wire logic [7:0]             rx_data,
    // Characters to the serialiser.
    output logic                        tx_valid,
    input  wire logic                   tx_ready,
    output logic [7:0]                  tx_data,
    // Modem pins, logic level.
    input  wire logic                   cts_pin,
    input  wire logic                   dsr_pin,
    input  wire logic                   ri_pin,
    input  wire logic                   cd_pin,
    output logic                        rts_pin,
    // Baud divisor and interrupt request.
    output logic [15:0]                 divisor,
    output logic                        irq
);
    import uefc_pkg::*;

    logic [7:0] interrupt_enable_reg;          // Interrupt enable.
    logic [7:0] fifo_control_reg;          // FIFO control, stored part.
    logic [7:0] lcr;          // Line control.
    logic [7:0] modem_control_reg;          // Modem control.
    logic [7:0] scratch_reg;          // Scratch.
    logic [7:0] enhanced_feature_control;          // Enhanced feature control.
    logic [7:0] flow_on_char_one;         // First Xon character.
    logic [7:0] flow_on_char_two;         // Second Xon character.
    logic [7:0] flow_off_char_one;        // First Xoff character.
    logic [7:0] flow_off_char_two;        // Second Xoff character.
    logic [7:0] isr_enh;      // Gated enhanced status bits 4-5.
    logic       thr_full;     // Transmit holding register loaded.
    logic       spec_f;       // Special character seen.
    logic       xoff_f;       // Xoff seen through the second pair.
    logic       rts_hold;     // Auto RTS asks the peer to stop.
    logic [3:0] msr_delta;    // Modem input change flags.
    logic [3:0] pin_prev;     // Modem inputs one cycle ago.
    logic [3:0] pins;         // Current modem inputs.
    logic       unlock;       // Enhanced bits may be written.
    logic       dlab;         // Divisor bank selected.
    logic       enh_bank;     // Enhanced bank selected.
    logic       wr_n;         // Write in the normal bank.
    logic       rd_n;         // Read in the normal bank.
    logic       match;        // Received char equals second Xoff.
    logic       spec_hit;     // Accepted char is a special match.
    logic       drop;         // Accepted char must not be stored.
    logic       f_valid;      // Push request into the buffer.
    logic       f_ready;      // Buffer has room.
    logic       f_out_v;      // Buffer holds a character.
    logic       f_pop;        // Host read of the holding register.
    logic [7:0] f_data;       // Oldest stored character.
    logic [$clog2(DEPTH):0] f_cnt;  // Buffer level.
    logic [4:0] lvl;          // Programmed trigger level.
    logic [4:0] lvl_hi;       // One level above.
    logic [4:0] lvl_lo;       // One level below.
    logic       trig;         // Level reached under auto RTS.
    logic [7:0] next_rdata;   // Read mux result.

    // Only the gated bits are protected; the rest always follow the write.
    function automatic logic [7:0] gate(input logic [7:0] old, input logic [7:0] nw,
                                        input logic [7:0] m, input logic en);
        gate = en ? nw : ((nw & ~m) | (old & m));
    endfunction

    assign pins     = {cd_pin, ri_pin, dsr_pin, cts_pin};
    assign unlock   = enhanced_feature_control[UEFC_EFR_UNLOCK];
    assign dlab     = lcr[7];
    assign enh_bank = (lcr == UEFC_ENH_KEY);
    assign wr_n     = bus.wr && !dlab;
    assign rd_n     = bus.rd && !dlab;

    // Bit 0 of the stored character lines up with the received LSB.
    assign match = enhanced_feature_control[UEFC_EFR_SPEC] && (rx_data == flow_off_char_two);
    // Second-pair compare swallows the match; first pair stores it.
    assign spec_hit = rx_valid && rx_ready && match;
    assign drop     = match && (enhanced_feature_control[1:0] == UEFC_RX_PAIR2);
    assign f_valid  = rx_valid && !drop;
    assign rx_ready = drop || f_ready;
    assign f_pop    = rd_n && (bus.addr == UEFC_A_DATA);

    uefc_fifo #(.W(8), .D(DEPTH)) u_fifo (
        .clk     (clk),
        .rst_n   (rst_n),
        .clr     (wr_n && bus.addr == UEFC_A_FCR && bus.wdata[1]),
        .s_valid (f_valid),
        .s_ready (f_ready),
        .s_data  (rx_data),
        .m_valid (f_out_v),
        .m_ready (f_pop),
        .m_data  (f_data),
        .count   (f_cnt)
    );

    // Interrupt enable; upper nibble only while unlocked.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            interrupt_enable_reg <= UEFC_RST_REG;
        end else if (wr_n && bus.addr == UEFC_A_IER) begin
            interrupt_enable_reg <= gate(interrupt_enable_reg, bus.wdata, UEFC_IER_ENH, unlock);
        end
    end

    // FIFO control; reset bit 1 acts on the write, and bits 1-2 are not kept.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fifo_control_reg <= UEFC_RST_REG;
        end else if (wr_n && bus.addr == UEFC_A_FCR) begin
            fifo_control_reg <= gate(fifo_control_reg, bus.wdata & 8'hF9, UEFC_FCR_ENH, unlock);
        end
    end

    // Status bits 4-5 written through the same port as FIFO control
    // are held as enhanced settings, frozen while locked.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            isr_enh <= UEFC_RST_REG;
        end else if (wr_n && bus.addr == UEFC_A_FCR && unlock) begin
            isr_enh <= bus.wdata & UEFC_ISR_ENH;
        end
    end

    // Modem control; bits 2 and 5-7 only while unlocked.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            modem_control_reg <= UEFC_RST_REG;
        end else if (!enh_bank && bus.wr && bus.addr == UEFC_A_MCR) begin
            modem_control_reg <= gate(modem_control_reg, bus.wdata, UEFC_MCR_ENH, unlock);
        end
    end

    // Line control is written in every bank; scratch only while line control bit 7 is clear.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lcr <= UEFC_RST_REG;
            scratch_reg <= UEFC_RST_SPR;
        end else if (bus.wr && bus.addr == UEFC_A_LCR) begin
            lcr <= bus.wdata;
        end else if (wr_n && bus.addr == UEFC_A_SPR) begin
            scratch_reg <= bus.wdata;
        end
    end

    // Enhanced feature register. A new select value is taken only from
    // zero or to zero, so a glitch through a mixed setting cannot occur.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            enhanced_feature_control <= UEFC_RST_REG;
        end else if (enh_bank && bus.wr && bus.addr == UEFC_A_EFR) begin
            enhanced_feature_control[7:4] <= bus.wdata[7:4];
            if (enhanced_feature_control[3:0] == 4'h0 || bus.wdata[3:0] == 4'h0) begin
                enhanced_feature_control[3:0] <= bus.wdata[3:0];
            end
        end
    end

    // Flow characters; write only, cleared by the reset pin only.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            flow_on_char_one  <= UEFC_RST_REG;
            flow_on_char_two  <= UEFC_RST_REG;
            flow_off_char_one <= UEFC_RST_REG;
            flow_off_char_two <= UEFC_RST_REG;
        end else if (enh_bank && bus.wr) begin
            if (bus.addr == UEFC_A_FLOW_ON_CHAR_ONE) begin
                flow_on_char_one <= bus.wdata;
            end
            if (bus.addr == UEFC_A_FLOW_ON_CHAR_TWO) begin
                flow_on_char_two <= bus.wdata;
            end
            if (bus.addr == UEFC_A_XOF1) begin
                flow_off_char_one <= bus.wdata;
            end
            if (bus.addr == UEFC_A_XOF2) begin
                flow_off_char_two <= bus.wdata;
            end
        end
    end

    // Divisor survives the reset pin; only power-on reloads it.
    always_ff @(posedge clk) begin
        if (!por_n) begin
            divisor <= UEFC_RST_DIV;
        end else if (dlab && !enh_bank && bus.wr && bus.addr == UEFC_A_DLL) begin
            divisor[7:0] <= bus.wdata;
        end else if (dlab && !enh_bank && bus.wr && bus.addr == UEFC_A_DLM) begin
            divisor[15:8] <= bus.wdata;
        end
    end

    // Special-character and Xoff flags; a new hit beats the clearing read.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            spec_f <= 1'b0;
            xoff_f <= 1'b0;
        end else begin
            if (spec_hit) begin
                spec_f <= 1'b1;
            end else if (rd_n && bus.addr == UEFC_A_FCR) begin
                spec_f <= 1'b0;
            end
            if (spec_hit && drop) begin
                xoff_f <= 1'b1;
            end else if (rd_n && bus.addr == UEFC_A_FCR) begin
                xoff_f <= 1'b0;
            end
        end
    end

    // Modem deltas; the sample taken during reset avoids a false change.
    always_ff @(posedge clk) begin
        pin_prev <= pins;
        if (!rst_n) begin
            msr_delta <= 4'h0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (pins[i] != pin_prev[i]) begin
                    msr_delta[i] <= 1'b1;
                end else if (rd_n && bus.addr == UEFC_A_MSR) begin
                    msr_delta[i] <= 1'b0;
                end
            end
        end
    end

    // Trigger levels picked by the top two FIFO control bits.
    assign lvl    = UEFC_TRIG_LVL[fifo_control_reg[7:6]*5 +: 5];
    assign lvl_hi = UEFC_TRIG_HI[fifo_control_reg[7:6]*5 +: 5];
    assign lvl_lo = UEFC_TRIG_LO[fifo_control_reg[7:6]*5 +: 5];
    assign trig   = enhanced_feature_control[UEFC_EFR_ARTS] && (5'(f_cnt) >= lvl);

    // Hysteresis on the auto RTS request; between the bounds it holds.
    always_ff @(posedge clk) begin
        if (!rst_n || !enhanced_feature_control[UEFC_EFR_ARTS]) begin
            rts_hold <= 1'b0;
        end else if (5'(f_cnt) >= lvl_hi) begin
            rts_hold <= 1'b1;
        end else if (5'(f_cnt) < lvl_lo) begin
            rts_hold <= 1'b0;
        end
    end

    // Auto RTS takes the pin only once software has asserted RTS;
    // otherwise the pin is a plain software output (bit set = LOW).
    assign rts_pin = (enhanced_feature_control[UEFC_EFR_ARTS] && modem_control_reg[1]) ? rts_hold : !modem_control_reg[1];

    // Transmit holding register, emptied by the serialiser.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            thr_full <= 1'b0;
            tx_data  <= UEFC_RST_REG;
        end else if (wr_n && bus.addr == UEFC_A_DATA) begin
            thr_full <= 1'b1;
            tx_data  <= bus.wdata;
        end else if (tx_valid && tx_ready) begin
            thr_full <= 1'b0;
        end
    end

    // A high CTS stops the next character; one in flight finishes.
    assign tx_valid = thr_full && !(enhanced_feature_control[UEFC_EFR_ACTS] && cts_pin);

    // Interrupt request from the enabled sources.
    assign irq = (interrupt_enable_reg[0] && (trig || (f_out_v && !enhanced_feature_control[UEFC_EFR_ARTS])))
               || (interrupt_enable_reg[5] && (spec_f || xoff_f));

    // Read multiplexer; write-only and unmapped addresses read zero.
    always_comb begin
        next_rdata = 8'h00;
        if (enh_bank && bus.addr == UEFC_A_EFR) begin
            next_rdata = enhanced_feature_control;
        end else if (dlab && !enh_bank && bus.addr == UEFC_A_DLL) begin
            next_rdata = divisor[7:0];
        end else if (dlab && !enh_bank && bus.addr == UEFC_A_DLM) begin
            next_rdata = divisor[15:8];
        end else if (!enh_bank || bus.addr < UEFC_A_FLOW_ON_CHAR_ONE) begin
            unique case (bus.addr)
                UEFC_A_DATA: next_rdata = f_data;
                UEFC_A_IER:  next_rdata = interrupt_enable_reg;
                UEFC_A_FCR:  next_rdata = {{2{fifo_control_reg[0]}}, xoff_f, spec_f, 3'h0, !irq}
                                         | isr_enh;
                UEFC_A_LCR:  next_rdata = lcr;
                UEFC_A_MCR:  next_rdata = modem_control_reg;
                UEFC_A_LSR:  next_rdata = {1'b0, {2{!thr_full}}, 4'h0, f_out_v};
                UEFC_A_MSR:  next_rdata = {~pins, msr_delta};
                UEFC_A_SPR:  next_rdata = scratch_reg;
            endcase
        end
    end

    // Read data are registered one cycle after the strobe.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata <= 8'h00;
        end else if (bus.rd) begin
            rdata <= next_rdata;
        end
    end

    // Locked writes leave the upper interrupt-enable bits alone.
    lock_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_n && bus.addr == UEFC_A_IER && !unlock) |=> interrupt_enable_reg[7:4] == $past(interrupt_enable_reg[7:4]))
        else $error("Locked write changed enhanced enable bits");

    // Feature, interrupt-enable, modem and FIFO control registers leave reset cleared.
    reset_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(rst_n) |-> (enhanced_feature_control == 8'h00 && interrupt_enable_reg == 8'h00 && modem_control_reg == 8'h00 && fifo_control_reg == 8'h00))
        else $error("Enhanced bits not cleared by reset");

    // A stored special match flags status bit four next cycle.
    spec_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
        (spec_hit && !drop) |=> (spec_f && f_cnt != '0))
        else $error("Special match not flagged or not stored");

    // A second-pair match never enters the buffer yet raises both flags.
    xoff_drop_a: assert property (@(posedge clk) disable iff (!rst_n)
        (spec_hit && drop) |-> !f_valid ##1 (xoff_f && spec_f))
        else $error("Second Xoff stored or not flagged");

    // Auto RTS goes high once the upper level is reached.
    rts_high_a: assert property (@(posedge clk) disable iff (!rst_n)
        (enhanced_feature_control[UEFC_EFR_ARTS] && modem_control_reg[1] && 5'(f_cnt) >= lvl_hi)
        |=> (rts_pin || !enhanced_feature_control[UEFC_EFR_ARTS]))
        else $error("Auto RTS not deasserted above level");

    // Without auto RTS the pin mirrors the software bit.
    rts_soft_a: assert property (@(posedge clk) disable iff (!rst_n)
        !enhanced_feature_control[UEFC_EFR_ARTS] |-> (rts_pin == !modem_control_reg[1]))
        else $error("RTS pin does not follow software");

    // Auto CTS holds off transmit while CTS is high.
    cts_halt_a: assert property (@(posedge clk) disable iff (!rst_n)
        (enhanced_feature_control[UEFC_EFR_ACTS] && cts_pin) |-> !tx_valid)
        else $error("Transmit offered while CTS high");

    // Flow characters come out of reset at zero.
    xchar_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(rst_n) |-> (flow_on_char_one == 8'h00 && flow_on_char_two == 8'h00 && flow_off_char_one == 8'h00 && flow_off_char_two == 8'h00))
        else $error("Flow characters not cleared");

    // The reset pin alone keeps the divisor.
    div_keep_a: assert property (@(posedge clk) disable iff (!por_n)
        (!rst_n && !bus.wr) |=> divisor == $past(divisor))
        else $error("Divisor changed by pin reset");

    // Select bits never jump between two non-zero settings.
    efr_sel_a: assert property (@(posedge clk) disable iff (!rst_n)
        ($past(enhanced_feature_control[3:0]) != 4'h0 && enhanced_feature_control[3:0] != 4'h0) |-> enhanced_feature_control[3:0] == $past(enhanced_feature_control[3:0]))
        else $error("Flow select changed without passing zero");
endmodule

// file: core/uefc_fifo.sv
`timescale 1ns/1ps
module uefc_fifo #(
    parameter int W = 8,
    parameter int D = 16
) (
    // Clock and reset.
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic                 clr,
    // Fill side.
    input  wire logic                 s_valid,
    output logic                      s_ready,
    input  wire logic [W-1:0]         s_data,
    // Drain side.
    output logic                      m_valid,
    input  wire logic                 m_ready,
    output logic [W-1:0]              m_data,
    // Fill level.
    output logic [$clog2(D):0]        count
);
    localparam int AW = $clog2(D);

    logic [W-1:0]  mem [D];   // Storage words, each a register.
    logic [AW-1:0] wptr;      // Next slot to write.
    logic [AW-1:0] rptr;      // Oldest word.
    logic          push;      // Word accepted this cycle.
    logic          pop;       // Word drained this cycle.

    assign s_ready = (count != D[AW:0]);
    assign m_valid = (count != '0);
    assign push    = s_valid && s_ready;
    assign pop     = m_valid && m_ready;
    assign m_data  = mem[rptr];

    // Storage writes; no reset needed since count guards every read.
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wptr] <= s_data;
        end
    end

    // Pointers and level; a clear empties the buffer at once.
    always_ff @(posedge clk) begin
        if (!rst_n || clr) begin
            wptr  <= '0;
            rptr  <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wptr <= wptr + 1'b1;
            end
            if (pop) begin
                rptr <= rptr + 1'b1;
            end
            count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule

// file: inc/uefc_pkg.sv
package uefc_pkg;
    // Register indices on the 3-bit host address, normal bank.
    localparam logic [2:0] UEFC_A_DATA = 3'h0;
    localparam logic [2:0] UEFC_A_IER  = 3'h1;
    localparam logic [2:0] UEFC_A_FCR  = 3'h2;
    localparam logic [2:0] UEFC_A_LCR  = 3'h3;
    localparam logic [2:0] UEFC_A_MCR  = 3'h4;
    localparam logic [2:0] UEFC_A_LSR  = 3'h5;
    localparam logic [2:0] UEFC_A_MSR  = 3'h6;
    localparam logic [2:0] UEFC_A_SPR  = 3'h7;
    // Divisor bank (line control bit 7 set).
    localparam logic [2:0] UEFC_A_DLL  = 3'h0;
    localparam logic [2:0] UEFC_A_DLM  = 3'h1;
    // Enhanced bank (line control equal to the key).
    localparam logic [2:0] UEFC_A_EFR  = 3'h2;
    localparam logic [2:0] UEFC_A_FLOW_ON_CHAR_ONE = 3'h4;
    localparam logic [2:0] UEFC_A_FLOW_ON_CHAR_TWO = 3'h5;
    localparam logic [2:0] UEFC_A_XOF1 = 3'h6;
    localparam logic [2:0] UEFC_A_XOF2 = 3'h7;
    localparam logic [7:0] UEFC_ENH_KEY = 8'hBF;
    // Values after reset.
    localparam logic [7:0]  UEFC_RST_REG = 8'h00;
    localparam logic [7:0]  UEFC_RST_SPR = 8'hFF;
    localparam logic [15:0] UEFC_RST_DIV = 16'h0001;
    // Enhanced feature register bit positions.
    localparam int UEFC_EFR_UNLOCK = 4;
    localparam int UEFC_EFR_SPEC   = 5;
    localparam int UEFC_EFR_ARTS   = 6;
    localparam int UEFC_EFR_ACTS   = 7;
    // Bits that only change while the unlock bit is set.
    localparam logic [7:0] UEFC_IER_ENH = 8'hF0;
    localparam logic [7:0] UEFC_ISR_ENH = 8'h30;
    localparam logic [7:0] UEFC_FCR_ENH = 8'h30;
    localparam logic [7:0] UEFC_MCR_ENH = 8'hE4;
    // Receive flow-control compare selections.
    localparam logic [1:0] UEFC_RX_PAIR1 = 2'h2;
    localparam logic [1:0] UEFC_RX_PAIR2 = 2'h1;
    // Receive trigger levels, and the levels one above and one below.
    localparam logic [19:0] UEFC_TRIG_LVL = {5'h0E, 5'h08, 5'h04, 5'h01};
    localparam logic [19:0] UEFC_TRIG_HI  = {5'h10, 5'h0E, 5'h08, 5'h04};
    localparam logic [19:0] UEFC_TRIG_LO  = {5'h08, 5'h04, 5'h01, 5'h01};

    // One host bus request, sampled in a single cycle.
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } uefc_bus_req_s;
endpackage

// file: test/uart_enhanced_flow_control_tb.sv
`timescale 1ns/1ps
module uart_enhanced_flow_control_tb;
    import uefc_pkg::*;
    logic          clk, rst_n, por_n, rxv, rxr, txv, txr, cts, hold, rts, irq, rh;
    logic [7:0]    rdata, rxd, txd, got, v, x, y;
    logic [15:0]   divisor;
    uefc_bus_req_s bus;
    int            bad_count, checked, mq[$];
    integer        seed;
    uefc_core u_uefc_core (.clk(clk), .rst_n(rst_n), .por_n(por_n), .bus(bus), .rdata(rdata),
        .rx_valid(rxv), .rx_ready(rxr), .rx_data(rxd), .tx_valid(txv), .tx_ready(txr),
        .tx_data(txd), .cts_pin(cts), .dsr_pin(y[0]), .ri_pin(y[1]), .cd_pin(y[2]),
        .rts_pin(rts), .divisor(divisor), .irq(irq));
    uefc_peer u_uefc_peer (.clk(clk), .rx_valid(rxv), .rx_ready(rxr), .rx_data(rxd),
        .tx_valid(txv), .tx_ready(txr), .tx_data(txd), .hold_cts(hold), .cts_pin(cts), .got(got));
    initial begin
        clk = 1'h0;
        forever #4 clk = ~clk;
    end
    // Count a compare and report a difference at once.
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        checked++;
        if (s !== e) begin
            bad_count++;
            $display("mismatch at %0t seen %h expected %h", $time, s, e);
        end
    endtask
    // Bus cycles leave an idle cycle, so a strobe is never set twice at once.
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        bus = '{a, d, 1'h1, 1'h0};
        @(negedge clk);
        bus.wr = 1'h0;
        @(negedge clk);
    endtask
    task automatic rdc(input logic [2:0] a, input logic [7:0] e);
        bus = '{a, 8'h00, 1'h0, 1'h1};
        @(negedge clk);
        bus.rd = 1'h0;
        @(negedge clk);
        v = rdata;
        if (a != UEFC_A_MSR) chk(v, e);
    endtask
    // Reach the enhanced bank, write the feature register, return.
    task automatic enhanced_feature_control(input logic [7:0] d);
        wr(UEFC_A_LCR, UEFC_ENH_KEY);
        wr(UEFC_A_EFR, d);
        wr(UEFC_A_LCR, 8'h03);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Whole run needs well under this span.
    initial begin
        #400000;
        bad_count++;
        tally_and_finish;
    end
    initial begin
        seed = 32'hC0F33DEC;
        bus = '0;
        {rst_n, por_n, hold, rh} = 4'h0;
        x = 8'h80 | 8'($random(seed));
        y = 8'($random(seed));
        repeat (12) @(negedge clk);
        {rst_n, por_n} = 2'h3;
        rdc(UEFC_A_SPR, 8'hFF);
        rdc(UEFC_A_LSR, 8'h60);
        rdc(UEFC_A_FCR, 8'h01);
        rdc(UEFC_A_MSR, 8'h00);
        chk(v, {~y[2:0], 5'h10});
        chk(divisor, 16'h0001);
        wr(UEFC_A_LCR, UEFC_ENH_KEY);
        rdc(UEFC_A_EFR, 8'h00);
        for (int i = 4; i < 8; i++) begin
            rdc(3'(i), 8'h00);
            wr(3'(i), 8'(8'h10 + i));
            rdc(3'(i), 8'h00);
        end
        wr(UEFC_A_LCR, 8'h03);
        wr(UEFC_A_IER, 8'hF1);
        rdc(UEFC_A_IER, 8'h01);
        enhanced_feature_control(8'h10);
        wr(UEFC_A_IER, 8'hF1);
        rdc(UEFC_A_IER, 8'hF1);
        wr(UEFC_A_IER, 8'h00);
        $display("test gate done");
        wr(UEFC_A_LCR, UEFC_ENH_KEY);
        wr(UEFC_A_XOF2, x);
        enhanced_feature_control(8'h32);
        u_uefc_peer.send(x);
        rdc(UEFC_A_FCR, 8'h11);
        u_uefc_peer.send(x ^ 8'h01);
        rdc(UEFC_A_FCR, 8'h01);
        mq = '{x, x ^ 8'h01};
        while (mq.size() > 0) rdc(UEFC_A_DATA, 8'(mq.pop_front()));
        enhanced_feature_control(8'h30);
        enhanced_feature_control(8'h31);
        wr(UEFC_A_IER, 8'h20);
        u_uefc_peer.send(x);
        chk(irq, 1'h1);
        rdc(UEFC_A_FCR, 8'h30);
        chk(irq, 1'h0);
        rdc(UEFC_A_LSR, 8'h60);
        wr(UEFC_A_LCR, UEFC_ENH_KEY);
        wr(UEFC_A_EFR, 8'h32);
        rdc(UEFC_A_EFR, 8'h31);
        $display("test special done");
        enhanced_feature_control(8'h10);
        enhanced_feature_control(8'h50);
        wr(UEFC_A_MCR, 8'h02);
        wr(UEFC_A_FCR, 8'h41);
        wr(UEFC_A_IER, 8'h01);
        chk(rts, 1'h0);
        for (int i = 0; i < 16; i++) begin
            u_uefc_peer.send(8'(i * 17));
            mq.push_back(i * 17);
            repeat (2) @(negedge clk);
            if (mq.size() >= 8) rh = 1'h1;
            chk(rts, rh);
            chk(irq, mq.size() >= 4);
        end
        chk(rxr, 1'h0);
        while (mq.size() > 0) begin
            rdc(UEFC_A_DATA, 8'(mq.pop_front()));
            if (mq.size() < 1) rh = 1'h0;
            chk(rts, rh);
        end
        enhanced_feature_control(8'h10);
        chk(rts, 1'h0);
        wr(UEFC_A_MCR, 8'h00);
        chk(rts, 1'h1);
        $display("test rts done");
        enhanced_feature_control(8'h90);
        hold = 1'h1;
        rdc(UEFC_A_MSR, 8'h00);
        chk(v[4], 1'h0);
        wr(UEFC_A_DATA, y);
        repeat (6) @(negedge clk);
        chk(txv, 1'h0);
        hold = 1'h0;
        repeat (6) @(negedge clk);
        chk(got, y);
        $display("test cts done");
        wr(UEFC_A_LCR, 8'h80);
        wr(UEFC_A_DLL, 8'h34);
        wr(UEFC_A_DLM, 8'h12);
        rst_n = 1'h0;
        repeat (2) @(negedge clk);
        rst_n = 1'h1;
        chk(divisor, 16'h1234);
        rdc(UEFC_A_IER, 8'h00);
        rdc(UEFC_A_MSR, 8'h00);
        chk(v, {~y[2:0], 5'h10});
        wr(UEFC_A_LCR, UEFC_ENH_KEY);
        rdc(UEFC_A_EFR, 8'h00);
        por_n = 1'h0;
        repeat (2) @(negedge clk);
        por_n = 1'h1;
        chk(divisor, 16'h0001);
        $display("test reset done");
        tally_and_finish;
    end
endmodule

// file: test/uefc_peer.sv
`timescale 1ns/1ps
// Remote serial peer: offers received bytes, takes sent ones, stalls often.
module uefc_peer (
    input  wire logic       clk,
    output logic            rx_valid,
    input  wire logic       rx_ready,
    output logic [7:0]      rx_data,
    input  wire logic       tx_valid,
    output logic            tx_ready,
    input  wire logic [7:0] tx_data,
    input  wire logic       hold_cts,
    output logic            cts_pin,
    output logic [7:0]      got
);
    // A high level asks the block to stop sending.
    assign cts_pin = hold_cts;
    initial begin
        rx_valid = 1'h0;
        rx_data = 8'h00;
        tx_ready = 1'h0;
    end
    // Ready every other cycle, so a held request is needed.
    always @(negedge clk) tx_ready <= ~tx_ready;
    always @(posedge clk) if (tx_valid && tx_ready) got <= tx_data;
    // Offer one byte and hold it until taken, with a bounded wait.
    task automatic send(input logic [7:0] b);
        int n;
        n = 0;
        @(negedge clk);
        rx_valid = 1'h1;
        rx_data = b;
        @(posedge clk);
        while (!rx_ready && n < 99) begin
            n++;
            @(posedge clk);
        end
        @(negedge clk);
        rx_valid = 1'h0;
        rx_data = ~b; // Released line must not keep the old value.
    endtask
endmodule
